// file: src/src_pkg.sv
// Purpose: constants and carrier types for the sonar ranging control block
// Assumes: 10 MHz system clock; all pins synchronous to it
// Notes: times kept in their own units, cycle counts derived from them
package src_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int CLK_PERIOD_NS = 100;
    // 420 kHz time base: derived from clk by a fractional accumulator
    localparam int TB_HZ = 420000;
    // two periods span a whole number of ticks; halves run 4,4,4,5 (burst) and 2,2,2,3
    localparam int BURST_DIV2 = 17; // 2 * 420k / 17 = 49.4 kHz during the burst
    localparam int POST_DIV2 = 9;   // 2 * 420k / 9 = 93.3 kHz after the burst
    localparam int BURST_PULSES = 16;
    localparam int POWERUP_MS = 5;
    localparam int POWERUP_TICKS = POWERUP_MS * TB_HZ / 1000;
    localparam int TRANSMIT_DRIVE_SIGNAL_US = 1100;
    localparam int TRANSMIT_DRIVE_SIGNAL_TICKS = TRANSMIT_DRIVE_SIGNAL_US * TB_HZ / 1000000;
    localparam int BLANK_US = 2380;
    localparam int BLANK_TICKS = BLANK_US * TB_HZ / 1000000;
    localparam int GAIN_STEP_US = 2400;
    localparam int GAIN_STEP_TICKS = GAIN_STEP_US * TB_HZ / 1000000;
    localparam int GAIN_W = 4;
    localparam logic [GAIN_W-1:0] GAIN_MAX = 4'hf;
    localparam int CNT_W = 12;

    typedef enum {ST_RESET, ST_IDLE, ST_BURST, ST_BLANK, ST_LISTEN} src_state_e;

    typedef struct packed {
        logic transducer_drive_output;
        logic transmit_drive_signal;
        logic timebase_clock_output;
        logic echo_output;
        logic [GAIN_W-1:0] gain_setting;
    } src_out_s;

    typedef struct packed {
        src_state_e state;
        logic [23:0] tb_acc;
        logic [CNT_W-1:0] tick_cnt;
        logic [3:0] div_cnt;
        logic [1:0] half_ph;
        logic [4:0] pulse_cnt;
        logic [CNT_W-1:0] gain_cnt;
        logic init_d;
        logic echo_reset_blanking_input_d;
        src_out_s out;
    } src_state_s;
endpackage : src_pkg

// file: src/src_sonar_ranging_control.sv
// Purpose: timing and echo logic of an ultrasonic ranging module
// Assumes: inputs synchronous to clk; analog drive and receiver outside
// Notes: half periods vary in length (three short, one long) so both rates average out on whole ticks
// Operation
// - All logic is held in reset until the power-up interval has elapsed.
// - An initiate rising edge gives sixteen transducer pulses, then pulsing stops.
// - All timing is counted in ticks of a 420 kHz time base.
// - A time base clock output runs at the burst rate, then at the faster rate.
// - Transmit drive is high for about 1.1 ms and then stays idle.
// - In multiple-echo mode the blanking input excludes echoes already seen.
// - Power-up, initiation, burst and early unblanking do not depend on the mode.
// - Receive gain steps up under digital control through each cycle.
// - The receive input is ignored for 2.38 ms after initiation.
// - Early unblank high after the burst ends blanking at once and starts listening.
// - The echo output rises when a return is seen after blanking.
// - A blanking pulse clears the echo output to await the next return.
`timescale 1ns/1ps
module src_sonar_ranging_control (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // host side
    input wire logic initiate_input,
    input wire logic echo_reset_blanking_input,
    input wire logic early_unblank_input,
    // receiver side
    input wire logic return_signal_input,
    // outputs
    output logic transducer_drive_output,
    output logic transmit_drive_signal,
    output logic timebase_clock_output,
    output logic echo_output,
    output logic [src_pkg::GAIN_W-1:0] gain_setting
);
    src_pkg::src_state_s s_reg;
    src_pkg::src_state_s s_next;
    logic tb_tick;
    logic [24:0] acc_sum;
    logic [3:0] burst_last;
    logic [3:0] post_last;

    // ticks in one half period: three short halves then one long one per two periods
    function automatic logic [3:0] half_ticks(input int two_per, input logic [1:0] ph);
        logic [3:0] base;
        base = 4'(two_per / 4);
        half_ticks = (ph == 2'h3) ? base + 4'(two_per % 4) : base;
    endfunction : half_ticks

    // fractional accumulator: one tick per 420 kHz period of the time base
    always_comb begin
        acc_sum = {1'b0, s_reg.tb_acc} + 25'(src_pkg::TB_HZ);
        tb_tick = (acc_sum >= 25'(src_pkg::CLK_HZ));
        // last divider count of the current half period, burst and after it
        burst_last = half_ticks(src_pkg::BURST_DIV2, s_reg.half_ph) - 4'h1;
        post_last = half_ticks(src_pkg::POST_DIV2, s_reg.half_ph) - 4'h1;
    end

    // next-state logic
    always_comb begin
        s_next = s_reg;
        s_next.tb_acc = tb_tick ? 24'(acc_sum - 25'(src_pkg::CLK_HZ)) : acc_sum[23:0];
        s_next.init_d = initiate_input;
        s_next.echo_reset_blanking_input_d = echo_reset_blanking_input;
        // the time base output stays quiet while the power-up wait runs
        if (tb_tick && s_reg.state != src_pkg::ST_RESET) begin
            s_next.div_cnt = s_reg.div_cnt + 4'h1;
            // time base clock output toggles at the end of each half period
            if (s_reg.state == src_pkg::ST_BURST) begin
                if (s_reg.div_cnt >= burst_last) begin
                    s_next.div_cnt = 4'h0;
                    s_next.half_ph = s_reg.half_ph + 2'h1;
                    s_next.out.timebase_clock_output = ~s_reg.out.timebase_clock_output;
                    s_next.out.transducer_drive_output = ~s_reg.out.transducer_drive_output;
                    if (s_reg.out.transducer_drive_output) begin
                        s_next.pulse_cnt = s_reg.pulse_cnt + 5'h1;
                    end
                end
            end else if (s_reg.div_cnt >= post_last) begin
                s_next.div_cnt = 4'h0;
                s_next.half_ph = s_reg.half_ph + 2'h1;
                s_next.out.timebase_clock_output = ~s_reg.out.timebase_clock_output;
            end
        end
        case (s_reg.state)
            src_pkg::ST_RESET: begin
                // hold everything quiet until the oscillator has settled
                if (tb_tick) begin
                    s_next.tick_cnt = s_reg.tick_cnt + 12'h1;
                end
                if (s_reg.tick_cnt >= 12'(src_pkg::POWERUP_TICKS)) begin
                    s_next.state = src_pkg::ST_IDLE;
                    s_next.tick_cnt = '0;
                end
            end
            src_pkg::ST_IDLE: begin
                // edge taken regardless of echo mode
                if (initiate_input && !s_reg.init_d) begin
                    s_next.state = src_pkg::ST_BURST;
                    s_next.tick_cnt = '0;
                    s_next.pulse_cnt = '0;
                    s_next.div_cnt = '0;
                    s_next.half_ph = '0;
                    s_next.gain_cnt = '0;
                    s_next.out.gain_setting = '0;
                    s_next.out.echo_output = 1'b0;
                    s_next.out.transducer_drive_output = 1'b0;
                    s_next.out.transmit_drive_signal = 1'b1;
                end
            end
            src_pkg::ST_BURST, src_pkg::ST_BLANK, src_pkg::ST_LISTEN: begin
                if (tb_tick) begin
                    s_next.tick_cnt = (s_reg.tick_cnt == '1) ? s_reg.tick_cnt
                                                             : s_reg.tick_cnt + 12'h1;
                    s_next.gain_cnt = s_reg.gain_cnt + 12'h1;
                    // gain climbs in steps until it saturates
                    if (s_reg.gain_cnt >= 12'(src_pkg::GAIN_STEP_TICKS - 1)) begin
                        s_next.gain_cnt = '0;
                        if (s_reg.out.gain_setting != src_pkg::GAIN_MAX) begin
                            s_next.out.gain_setting = s_reg.out.gain_setting + 4'h1;
                        end
                    end
                end
                if (s_reg.tick_cnt >= 12'(src_pkg::TRANSMIT_DRIVE_SIGNAL_TICKS)) begin
                    s_next.out.transmit_drive_signal = 1'b0;
                end
                if (s_reg.state == src_pkg::ST_BURST
                    && s_reg.pulse_cnt >= 5'(src_pkg::BURST_PULSES)) begin
                    s_next.out.transducer_drive_output = 1'b0;
                    s_next.state = src_pkg::ST_BLANK;
                end
                if (s_reg.state != src_pkg::ST_LISTEN
                    && (early_unblank_input
                        || s_reg.tick_cnt >= 12'(src_pkg::BLANK_TICKS))) begin
                    // unblank early but never cut the burst short
                    if (s_reg.state == src_pkg::ST_BLANK) begin
                        s_next.state = src_pkg::ST_LISTEN;
                    end
                end
                if (s_reg.state == src_pkg::ST_LISTEN) begin
                    if (return_signal_input && !echo_reset_blanking_input) begin
                        s_next.out.echo_output = 1'b1;
                    end else if (s_reg.echo_reset_blanking_input_d && !echo_reset_blanking_input) begin
                        s_next.out.echo_output = 1'b0;
                    end
                end
                if (!initiate_input) begin
                    // dropping initiate ends the cycle and cuts transmit short
                    s_next.state = src_pkg::ST_IDLE;
                    s_next.out.transducer_drive_output = 1'b0;
                    s_next.out.transmit_drive_signal = 1'b0;
                end
            end
            default: begin
                s_next.state = src_pkg::ST_RESET;
            end
        endcase
    end

    // single state register, frozen while clk_en is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{state: src_pkg::ST_RESET, default: '0};
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign transducer_drive_output = s_reg.out.transducer_drive_output;
    assign transmit_drive_signal = s_reg.out.transmit_drive_signal;
    assign timebase_clock_output = s_reg.out.timebase_clock_output;
    assign echo_output = s_reg.out.echo_output;
    assign gain_setting = s_reg.out.gain_setting;

    // checks: cycles with clk_en low are left out where a rule needs progress,
    // since a frozen block legally holds every output
    sequence burst_start_q;
        s_reg.state == src_pkg::ST_IDLE && initiate_input && !s_reg.init_d && clk_en;
    endsequence

    reset_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.state == src_pkg::ST_RESET
        |-> !transducer_drive_output && !echo_output && !timebase_clock_output)
        else $error("output active during power-up");
    burst_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.state == src_pkg::ST_BURST |-> s_reg.pulse_cnt <= 5'h10)
        else $error("burst exceeded sixteen pulses");
    drive_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.state inside {src_pkg::ST_BLANK, src_pkg::ST_LISTEN, src_pkg::ST_IDLE}
        |-> !transducer_drive_output)
        else $error("transducer toggling after burst");
    transmit_drive_signal_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        burst_start_q |=> transmit_drive_signal)
        else $error("transmit drive did not start");
    no_echo_blank_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.state == src_pkg::ST_BLANK |-> !echo_output)
        else $error("echo during blanking");
    unblank_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.state == src_pkg::ST_BLANK && early_unblank_input && initiate_input && clk_en
        |=> s_reg.state == src_pkg::ST_LISTEN)
        else $error("early unblank ignored");
    echo_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.state == src_pkg::ST_LISTEN && return_signal_input && initiate_input
        && !echo_reset_blanking_input && clk_en |=> echo_output)
        else $error("return not reported");
    echo_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.state == src_pkg::ST_LISTEN && s_reg.echo_reset_blanking_input_d && !echo_reset_blanking_input
        && !return_signal_input && initiate_input && clk_en |=> !echo_output)
        else $error("echo not cleared by blanking pulse");
    gain_mono_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.state == src_pkg::ST_LISTEN && $stable(s_reg.state)
        |-> gain_setting >= $past(gain_setting))
        else $error("gain decreased within cycle");
    transmit_drive_signal_end_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.state inside {src_pkg::ST_BURST, src_pkg::ST_BLANK, src_pkg::ST_LISTEN}
        && s_reg.tick_cnt >= 12'(src_pkg::TRANSMIT_DRIVE_SIGNAL_TICKS) && clk_en
        |=> !transmit_drive_signal)
        else $error("transmit drive ran past its interval");
    freeze_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !clk_en |=> $stable(s_reg))
        else $error("state moved while clock enable low");
endmodule : src_sonar_ranging_control

// file: dv/src_host_model.sv
// Purpose: host model driving initiate, echo reset and early unblank
// Assumes: pins change just after a rising clk edge
// Notes: recycle gap is far below 80 ms to keep the run short
`timescale 1ns/1ps
module src_host_model #(
    parameter int PWR_CYC = 51000,
    parameter int GAP_CYC = 200
) (
    // clock
    input wire logic clk,
    // host pins
    output logic initiate_input,
    output logic echo_reset_blanking_input,
    output logic early_unblank_input
);
    // all pins idle low from time zero
    initial begin
        initiate_input = 1'b0;
        echo_reset_blanking_input = 1'b0;
        early_unblank_input = 1'b0;
    end
    // power-up wait before the first real initiate
    task automatic power_wait();
        repeat (PWR_CYC) @(posedge clk);
    endtask : power_wait
    // lowering initiate ends a cycle; the gap spaces the next one
    task automatic set_init(input logic v);
        @(posedge clk);
        initiate_input <= v;
        if (!v) repeat (GAP_CYC) @(posedge clk);
    endtask : set_init
    // 0.44 ms echo reset pulse, high then low
    task automatic blank_pulse();
        @(posedge clk);
        echo_reset_blanking_input <= 1'b1;
        repeat (4400) @(posedge clk);
        echo_reset_blanking_input <= 1'b0;
    endtask : blank_pulse
    task automatic unblank(input logic v);
        @(posedge clk);
        early_unblank_input <= v;
    endtask : unblank
endmodule : src_host_model

// file: dv/tb.sv
// Purpose: self-checking bench for the sonar ranging control block
// Assumes: 10 MHz clk, one tick about 23.8 clk
// Notes: monitor pops queued notes as pulses and echoes appear
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic return_signal_input = 1'b0;
    logic initiate_input, echo_reset_blanking_input, early_unblank_input;
    logic transducer_drive_output, transmit_drive_signal, timebase_clock_output, echo_output;
    logic [src_pkg::GAIN_W-1:0] gain_setting;
    logic drv_d, tx_d, echo_d, osc_d;
    int n_fail = 0;
    int cmp_count = 0;
    int n_pulse, tx_len, tb_per, tx_len_d, tb_prev, n_osc, e0, exp_pulse;
    int q_pulse[$];
    logic q_echo[$];
    // 100 ns clock
    initial forever #50 clk = ~clk;
    src_host_model host_u (.clk(clk), .initiate_input(initiate_input),
        .echo_reset_blanking_input(echo_reset_blanking_input),
        .early_unblank_input(early_unblank_input));
    src_sonar_ranging_control dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .initiate_input(initiate_input),
        .echo_reset_blanking_input(echo_reset_blanking_input),
        .early_unblank_input(early_unblank_input),
        .return_signal_input(return_signal_input),
        .transducer_drive_output(transducer_drive_output),
        .transmit_drive_signal(transmit_drive_signal),
        .timebase_clock_output(timebase_clock_output),
        .echo_output(echo_output), .gain_setting(gain_setting));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic check_val(input string nm, input logic [3:0] exp, input logic [3:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : check_val
    task automatic check_range(input string nm, input int lo, input int hi, input int got);
        cmp_count++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask : check_range
    // bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_hi(ref logic s, input logic v, input int bound);
        int i;
        for (i = 0; i < bound && s !== v; i++) @(negedge clk);
        if (i >= bound) begin
            n_fail++;
            $display("mismatch wait expected %h seen timeout", v);
            conclude();
        end
    endtask : wait_hi
    // monitor samples settled outputs on the falling edge
    always @(negedge clk) begin
        tb_per++;
        tx_len = transmit_drive_signal ? tx_len + 1 : 0;
        if (transmit_drive_signal && !tx_d) n_pulse = 0;
        if (transducer_drive_output && !drv_d) n_pulse++;
        if (timebase_clock_output && !osc_d) begin
            // two whole periods: about 405 clk at 49.4 kHz, about 214 clk at 93.3 kHz
            if (n_pulse > 2 && n_pulse < 16) begin
                check_range("osc burst", 400, 410, tb_per + tb_prev);
            end
            if (tx_len > 5000) check_range("osc after", 210, 220, tb_per + tb_prev);
            tb_prev = tb_per;
            tb_per = 0;
        end
        if (timebase_clock_output !== osc_d) n_osc++;
        if (!transmit_drive_signal && tx_d) begin
            exp_pulse = q_pulse.pop_front();
            check_range("pulses", exp_pulse, exp_pulse, n_pulse);
            check_range("tx length", 10890, 11110, tx_len_d);
        end
        // an echo with no note pending is an unexpected return
        if (echo_output && !echo_d) begin
            check_val("echo", q_echo.size() ? q_echo.pop_front() : 1'b0, 1'b1);
        end
        {drv_d, tx_d, echo_d, osc_d} = {transducer_drive_output, transmit_drive_signal,
            echo_output, timebase_clock_output};
        tx_len_d = tx_len;
    end
    // main sequence: power-up, unblanked multi-echo cycle, full blanking cycle
    initial begin
        void'($urandom(32'hf165));
        {drv_d, tx_d, echo_d, osc_d} = 4'h0;
        {n_pulse, tx_len, tb_per, tx_len_d} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // early initiate on purpose, inside the power-up interval
        repeat (1000) @(posedge clk);
        host_u.set_init(1'b1);
        repeat (300) @(negedge clk);
        check_val("tx in power-up", 0, transmit_drive_signal);
        host_u.set_init(1'b0);
        host_u.power_wait();
        q_pulse.push_back(16);
        host_u.set_init(1'b1);
        @(posedge clk);
        @(negedge clk);
        check_val("tx start", 1, transmit_drive_signal);
        check_val("gain start", 0, gain_setting);
        // random returns during burst and blanking must be ignored
        repeat (4000) begin
            @(posedge clk);
            return_signal_input <= 1'($urandom);
        end
        @(posedge clk);
        return_signal_input <= 1'b0;
        host_u.unblank(1'b1);
        host_u.unblank(1'b0);
        q_echo.push_back(1'b1);
        @(posedge clk);
        return_signal_input <= 1'b1;
        wait_hi(echo_output, 1'b1, 10);
        @(posedge clk);
        return_signal_input <= 1'b0;
        host_u.blank_pulse();
        repeat (2) @(negedge clk);
        check_val("echo cleared", 0, echo_output);
        q_echo.push_back(1'b1);
        @(posedge clk);
        return_signal_input <= 1'b1;
        wait_hi(echo_output, 1'b1, 10);
        wait_hi(transmit_drive_signal, 1'b0, 4000);
        @(posedge clk);
        return_signal_input <= 1'b0;
        host_u.set_init(1'b0);
        // freeze in idle: with clock enable low the time base output must not move
        @(posedge clk);
        clk_en <= 1'b0;
        repeat (2) @(negedge clk);
        e0 = n_osc;
        repeat (200 + $urandom % 100) @(negedge clk);
        check_range("osc frozen", e0, e0, n_osc);
        @(posedge clk);
        clk_en <= 1'b1;
        // second cycle: return held high, echo only after 2.38 ms
        q_pulse.push_back(16);
        q_echo.push_back(1'b1);
        host_u.set_init(1'b1);
        @(posedge clk);
        return_signal_input <= 1'b1;
        repeat (23500) @(negedge clk);
        check_val("echo in blank", 0, echo_output);
        wait_hi(echo_output, 1'b1, 700);
        repeat (500) @(negedge clk);
        check_val("gain step", 1, gain_setting);
        check_range("notes left", 0, 0, q_pulse.size() + q_echo.size());
        conclude();
    end
endmodule : tb
